//--- sps_map.svh
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// System clock rate in MHz
`define SPS_MCLK_MHZ        20

// Overcurrent blanking after each chopping turn-on, in ns
`define SPS_BLANK_NS        5500
// Least blanking rounds up to whole cycles
`define SPS_BLANK_CYC       ((`SPS_BLANK_NS * `SPS_MCLK_MHZ + 999) / 1000)
// Width of the blanking counter and its register field
`define SPS_BLANK_W         8

// Register byte offsets on the APB slave
`define SPS_ADDR_W          8
`define SPS_OFS_STATUS      8'h00
`define SPS_OFS_BLANK       8'h04

// Status word field positions
`define SPS_ST_POS_LSB      0
`define SPS_ST_EXC_BIT      3
`define SPS_ST_EDGE_BIT     4
`define SPS_ST_DIR_BIT      5
`define SPS_ST_EN_BIT       6
`define SPS_ST_OC_BIT       7
`define SPS_ST_OT_BIT       8
`define SPS_ST_DRV_LSB      9

// Coil pattern per half-step position, bits {a_fwd, a_rev, b_fwd, b_rev}
`define SPS_PAT_0           4'h9
`define SPS_PAT_1           4'h8
`define SPS_PAT_2           4'ha
`define SPS_PAT_3           4'h2
`define SPS_PAT_4           4'h6
`define SPS_PAT_5           4'h4
`define SPS_PAT_6           4'h5
`define SPS_PAT_7           4'h1

// Initial position after any reset
`define SPS_POS_INIT        3'h0

`endif

//--- sps_pkg.sv
package sps_pkg;

   // Position in the eight-entry half-step table
   typedef logic [2:0] sps_pos_t;

   // Four coil drives, {a_fwd, a_rev, b_fwd, b_rev}
   typedef logic [3:0] sps_drive_t;

   // Stepping order selected by the direction pin
   typedef enum logic {
      SPS_CW  = 1'b0,
      SPS_CCW = 1'b1
   } sps_dir_e;

   // Excitation pattern selected by the excitation pin
   typedef enum logic {
      SPS_FULL = 1'b0,
      SPS_HALF = 1'b1
   } sps_exc_e;

endpackage

//--- sps_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, one lane per bit
module sps_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;  // First stage, read only by the second

   // One pair of flops per bit
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

//--- sps_fault_latch.sv
`timescale 1ns/1ps
`include "sps_map.svh"
// Latched overcurrent and overheat detection with turn-on blanking
module sps_fault_latch (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Clear request, held while the sequencer reset pin is low
   input  wire logic                    clear,
   // Detection runs only while the device is enabled
   input  wire logic                    active,
   // Synchronised detector levels
   input  wire logic                    chop_on,
   input  wire logic                    over_current,
   input  wire logic                    over_heat,
   // Blanking length in cycles
   input  wire logic [`SPS_BLANK_W-1:0] blank_cycles,
   // Latched causes
   output logic                         oc_latched,
   output logic                         ot_latched
);

   logic                    chop_prev_reg;  // Last chop level, for turn-on edge
   logic [`SPS_BLANK_W-1:0] blank_reg;      // Cycles of blanking still to run
   logic                    chop_start;     // Turn-on of a chopping period
   logic                    oc_event;       // Qualified overcurrent

   assign chop_start = chop_on & ~chop_prev_reg;
   // Ringing right after turn-on must not trip the latch, nor in the turn-on cycle
   assign oc_event   = active & over_current & ~chop_start & (blank_reg == '0);  // [R17]

   // Chop edge history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chop_prev_reg <= 1'b0;
      end else begin
         chop_prev_reg <= chop_on;
      end
   end

   // Blanking counter restarts on every turn-on while enabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         blank_reg <= '0;
      end else if (active && chop_start) begin
         blank_reg <= blank_cycles;  // [R17]
      end else if (blank_reg != '0) begin
         blank_reg <= blank_reg - 1'b1;
      end
   end

   // Overcurrent latch, a new detection wins over a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oc_latched <= 1'b0;
      end else if (oc_event) begin
         oc_latched <= 1'b1;  // [R15]
      end else if (clear) begin
         oc_latched <= 1'b0;  // [R15]
      end
   end

   // Overheat latch, same priority
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ot_latched <= 1'b0;
      end else if (active && over_heat) begin
         ot_latched <= 1'b1;  // [R15]
      end else if (clear) begin
         ot_latched <= 1'b0;  // [R15]
      end
   end

endmodule

//--- sps_stepper_phase_sequencer.sv
// Notes on behaviour
// [R1] Edge select high: step on rising edges only
// [R2] Edge select low: step on both edges
// [R3] Excitation low full step, high half step
// [R4] Direction low clockwise, high reverse order
// [R5] Reset release starts at first-fwd, second-rev
// [R6] Reset pin low holds the sequencer reset
// [R7] Enable low turns all coil drives off
// [R8] Enable high resumes from same position
// [R9] Fault pin pulled low on any detection
// [R10] Controller keeps modes still near step edges
// [R11] Controller limits step rate per mode
// [R12] Controller keeps step pulses wide enough
// [R13] Controller keeps both-edge duty 40 to 50%
// [R14] Controller keeps direction still near edges
// [R15] Detections latch until reset pin pulse
// [R16] Enable low freezes state against inputs
// [R17] Overcurrent blanked after each chopping turn-on
// [R18] Four two-on states, or eight alternating
// [R19] Mode change keeps the present phase position
// [R20] No step edges means excitation holds
`timescale 1ns/1ps
`include "sps_map.svh"
module sps_stepper_phase_sequencer (
   // System clock and power-on reset
   input  wire logic                   mclk,
   input  wire logic                   resetn,
   // Motion controller pins, asynchronous to mclk
   input  wire logic                   step_clock,
   input  wire logic                   step_edge_select,
   input  wire logic                   excitation_select,
   input  wire logic                   rotation_direction,
   input  wire logic                   sequencer_reset_n,
   input  wire logic                   enable,
   // Power stage detector pins, asynchronous to mclk
   input  wire logic                   chop_on,
   input  wire logic                   over_current,
   input  wire logic                   over_heat,
   // Coil drives
   output logic                        first_coil_fwd_drive,
   output logic                        first_coil_rev_drive,
   output logic                        second_coil_fwd_drive,
   output logic                        second_coil_rev_drive,
   // Open-drain fault flag, active low
   input  wire logic                   fault_n_in,
   output logic                        fault_n_out,
   output logic                        fault_n_oe,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`SPS_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr
);

   // Reset release chain
   logic                    rst_meta_reg;   // First reset stage
   logic                    rst_n;          // Released reset for all logic

   // Synchronised pins
   logic [8:0]              pins_sync;      // All asynchronous inputs after two flops
   logic                    step_s;         // Step clock level
   logic                    edge_s;         // Edge select level
   logic                    exc_s;          // Excitation select level
   logic                    dir_s;          // Direction level
   logic                    seq_rst_n_s;    // Sequencer reset pin level
   logic                    en_s;           // Enable level
   logic                    chop_s;         // Chopper turn-on level
   logic                    oc_s;           // Overcurrent comparator level
   logic                    ot_s;           // Overheat comparator level

   // Sequencer state
   logic                    step_prev_reg;  // Step clock as last seen while enabled
   sps_pkg::sps_pos_t       pos_reg;        // Position in the half-step table
   sps_pkg::sps_pos_t       pos_next;       // Position after a step
   sps_pkg::sps_drive_t     pat;            // Pattern for the present position
   sps_pkg::sps_drive_t     drive_reg;      // Registered coil drives
   logic                    step_rise;      // Rising step edge seen
   logic                    step_fall;      // Falling step edge seen
   logic                    step_go;        // Advance one step this cycle
   logic                    fault_any;      // Either cause latched

   // Registers
   logic [`SPS_BLANK_W-1:0] blank_reg;      // Blanking length in cycles
   logic                    oc_latched;     // Overcurrent cause
   logic                    ot_latched;     // Overheat cause
   logic [31:0]             status_word;    // Live status view
   logic                    apb_setup;      // Setup phase of a transfer
   logic                    apb_write;      // Access phase of a write

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // Every controller and detector pin crosses two flops before any logic looks at it
   sps_sync #(
      .W (9)
   ) u_sync (
      .clk      (mclk),
      .rst_n    (rst_n),
      .async_in ({ot_s_pin(over_heat), over_current, chop_on, enable, sequencer_reset_n,
                  rotation_direction, excitation_select, step_edge_select, step_clock}),
      .sync_out (pins_sync)
   );

   assign step_s      = pins_sync[0];
   assign edge_s      = pins_sync[1];
   assign exc_s       = pins_sync[2];
   assign dir_s       = pins_sync[3];
   assign seq_rst_n_s = pins_sync[4];
   assign en_s        = pins_sync[5];
   assign chop_s      = pins_sync[6];
   assign oc_s        = pins_sync[7];
   assign ot_s        = pins_sync[8];

   // Pass-through kept as a function so the pin list above stays in one order
   function automatic logic ot_s_pin(input logic v);
      ot_s_pin = v;
   endfunction

   // Step clock history; frozen while disabled, so a level left changed during the
   // disabled time is taken as an edge once enable returns
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         step_prev_reg <= 1'b0;
      end else if (en_s) begin
         step_prev_reg <= step_s;  // [R16]
      end
   end

   // Edge decode, on the second synchroniser stage only
   assign step_rise = step_s & ~step_prev_reg;
   assign step_fall = ~step_s & step_prev_reg;

   // Falling edges count only in both-edge mode; nothing steps while
   // disabled, in reset or under a latched fault
   always_comb begin
      step_go = 1'b0;
      if (en_s && seq_rst_n_s && !fault_any) begin  // [R16]
         if (edge_s) begin
            step_go = step_rise;  // [R1]
         end else begin
            step_go = step_rise | step_fall;  // [R2]
         end
      end
   end

   // Next position: half step moves one entry; full step moves two from an
   // even entry, and from an odd entry left by half step moves one so that
   // the rotor phase is kept rather than restarted
   always_comb begin
      pos_next = pos_reg;
      if (exc_s == sps_pkg::SPS_HALF || pos_reg[0]) begin  // [R3] [R19]
         if (dir_s == sps_pkg::SPS_CW) begin
            pos_next = pos_reg + 3'h1;  // [R4]
         end else begin
            pos_next = pos_reg - 3'h1;  // [R4]
         end
      end else begin
         if (dir_s == sps_pkg::SPS_CW) begin
            pos_next = pos_reg + 3'h2;  // [R18]
         end else begin
            pos_next = pos_reg - 3'h2;  // [R18]
         end
      end
   end

   // Position register; the reset pin holds the initial entry, so release
   // starts from the first-forward, second-reverse pair
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pos_reg <= `SPS_POS_INIT;
      end else if (!seq_rst_n_s) begin
         pos_reg <= `SPS_POS_INIT;  // [R5] [R6]
      end else if (step_go) begin
         pos_reg <= pos_next;
      end
      // Without a step the position simply holds  [R20]
   end

   // Pattern table; even entries have two adjacent coils on, odd ones one
   always_comb begin
      case (pos_reg)  // [R18]
         3'h0:    pat = `SPS_PAT_0;
         3'h1:    pat = `SPS_PAT_1;
         3'h2:    pat = `SPS_PAT_2;
         3'h3:    pat = `SPS_PAT_3;
         3'h4:    pat = `SPS_PAT_4;
         3'h5:    pat = `SPS_PAT_5;
         3'h6:    pat = `SPS_PAT_6;
         default: pat = `SPS_PAT_7;
      endcase
   end

   // Coil drives from flops; off while disabled, in reset or faulted, and
   // back to the held position as soon as enable returns
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         drive_reg <= 4'h0;
      end else if (!en_s || !seq_rst_n_s || fault_any) begin
         drive_reg <= 4'h0;  // [R7] [R15]
      end else begin
         drive_reg <= pat;  // [R8] [R20]
      end
   end

   assign first_coil_fwd_drive  = drive_reg[3];
   assign first_coil_rev_drive  = drive_reg[2];
   assign second_coil_fwd_drive = drive_reg[1];
   assign second_coil_rev_drive = drive_reg[0];

   // Detection latches; the reset pin low clears them
   sps_fault_latch u_fault (
      .clk          (mclk),
      .rst_n        (rst_n),
      .clear        (~seq_rst_n_s),
      .active       (en_s),
      .chop_on      (chop_s),
      .over_current (oc_s),
      .over_heat    (ot_s),
      .blank_cycles (blank_reg),
      .oc_latched   (oc_latched),
      .ot_latched   (ot_latched)
   );

   assign fault_any = oc_latched | ot_latched;

   // Open drain: only ever pulls low, never drives high
   assign fault_n_out = 1'b0;
   assign fault_n_oe  = fault_any;  // [R9]

   // APB phases; the slave never stretches an access
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign pready    = 1'b1;

   // Unmapped addresses answer with an error in the access phase
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         if (paddr == `SPS_OFS_STATUS) begin
            pslverr = pwrite;
         end else if (paddr == `SPS_OFS_BLANK) begin
            pslverr = 1'b0;
         end else begin
            pslverr = 1'b1;
         end
      end
   end

   // Live status view, including the inverted wired level of the fault line
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SPS_ST_POS_LSB +: 3] = pos_reg;
      status_word[`SPS_ST_EXC_BIT]      = exc_s;
      status_word[`SPS_ST_EDGE_BIT]     = edge_s;
      status_word[`SPS_ST_DIR_BIT]      = dir_s;
      status_word[`SPS_ST_EN_BIT]       = en_s;
      status_word[`SPS_ST_OC_BIT]       = oc_latched;
      status_word[`SPS_ST_OT_BIT]       = ot_latched;
      status_word[`SPS_ST_DRV_LSB +: 4] = drive_reg;
      status_word[13]                   = ~fault_n_in;
   end

   // Blanking length, written by software; default is the documented time
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         blank_reg <= `SPS_BLANK_W'(`SPS_BLANK_CYC);  // [R17]
      end else if (apb_write && paddr == `SPS_OFS_BLANK) begin
         blank_reg <= pwdata[`SPS_BLANK_W-1:0];
      end
   end

   // Read data is captured in the setup phase and stands for the access
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (apb_setup && !pwrite) begin
         if (paddr == `SPS_OFS_STATUS) begin
            prdata <= status_word;
         end else if (paddr == `SPS_OFS_BLANK) begin
            prdata <= {{(32-`SPS_BLANK_W){1'b0}}, blank_reg};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule

//--- sps_stepper_phase_sequencer_assertions.sv
`timescale 1ns/1ps
`include "sps_map.svh"
// Watches coil drives and the fault pin against the control pins
module sps_sequencer_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Controller and detector pins
   input wire logic step_clock,
   input wire logic step_edge_select,
   input wire logic excitation_select,
   input wire logic sequencer_reset_n,
   input wire logic enable,
   input wire logic over_heat,
   // Coil drives and fault enable
   input wire logic first_coil_fwd_drive,
   input wire logic first_coil_rev_drive,
   input wire logic second_coil_fwd_drive,
   input wire logic second_coil_rev_drive,
   input wire logic fault_n_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Drives as one nibble, same order as the pattern table
   wire logic [3:0] drv = {first_coil_fwd_drive, first_coil_rev_drive,
                           second_coil_fwd_drive, second_coil_rev_drive};
   // Stepping possible: enabled, out of reset, no fault
   wire logic       run_ok = enable && sequencer_reset_n && !fault_n_oe;
   // Nothing that may move the drives changes
   sequence quiet;
      $stable(step_clock) && $stable(enable) && $stable(sequencer_reset_n)
         && $stable(fault_n_oe) && $stable(excitation_select);
   endsequence
   // Falling step edge in rising-only mode, long after any setup change
   sequence fall_rise_only;
      (run_ok && step_edge_select)[*6] ##0 $fell(step_clock);
   endsequence
   // Falling step edge in both-edge mode
   sequence fall_both;
      (run_ok && !step_edge_select)[*6] ##0 $fell(step_clock);
   endsequence
   // Sequencer reset pin released while enabled
   sequence seq_release;
      (enable && !over_heat)[*4] ##0 $rose(sequencer_reset_n);
   endsequence
   // Latched fault seen with the reset pin high for a while
   sequence hold_fault;
      sequencer_reset_n[*4] ##0 fault_n_oe;
   endsequence

   chk_drive_off_disable: assert property ((!enable || fault_n_oe)[*5] |-> drv == 4'h0)
      else $error("Drives on while disabled or faulted");
   chk_drive_off_reset: assert property ((!sequencer_reset_n)[*5] |-> drv == 4'h0)
      else $error("Drives on while sequencer reset held");
   chk_coil_pairs: assert property (!(drv[3] && drv[2]) && !(drv[1] && drv[0]))
      else $error("Both ends of one coil driven");
   chk_hold_still: assert property (quiet[*8] |-> $stable(drv))
      else $error("Drives moved without a step edge");
   chk_fall_ignored: assert property (fall_rise_only |-> ##3 $stable(drv)[*4])
      else $error("Falling edge stepped in rising-only mode");
   chk_fall_steps: assert property (fall_both |-> ##[2:6] $changed(drv))
      else $error("Falling edge did not step in both-edge mode");
   chk_release_init: assert property (seq_release |-> ##[2:6] drv == `SPS_PAT_0)
      else $error("Reset release did not give the initial pattern");
   chk_heat_flag: assert property ((over_heat && enable)[*5] |-> ##[0:4] fault_n_oe)
      else $error("Overheat did not pull the fault line");
   chk_fault_latched: assert property (hold_fault |=> fault_n_oe)
      else $error("Fault cleared without a reset pulse");
endmodule

bind sps_stepper_phase_sequencer sps_sequencer_chk chk (
   .mclk, .resetn, .step_clock, .step_edge_select, .excitation_select,
   .sequencer_reset_n, .enable, .over_heat, .first_coil_fwd_drive,
   .first_coil_rev_drive, .second_coil_fwd_drive, .second_coil_rev_drive, .fault_n_oe
);

//--- sps_motion_ctrl.sv
`timescale 1ns/1ps
// Motion controller model: step clock bursts and control levels
module sps_motion_ctrl (
   // System clock, paces level changes only
   input wire logic mclk,
   // Controller pins
   output logic     step_clock,
   output logic     step_edge_select,
   output logic     excitation_select,
   output logic     rotation_direction,
   output logic     sequencer_reset_n,
   output logic     enable
);
   // Half period of the step clock, ns
   localparam int HALF_NS = 200;
   // Clock parked low, sequencer held in reset
   initial begin
      step_clock = 1'b0;
      step_edge_select = 1'b0;
      excitation_select = 1'b0;
      rotation_direction = 1'b0;
      sequencer_reset_n = 1'b0;
      enable = 1'b1;
   end
   // Modes change only with the clock parked, then settle
   task automatic set_mode(input logic exc, input logic edg, input logic dir);
      @(posedge mclk);
      excitation_select <= exc;
      step_edge_select <= edg;
      rotation_direction <= dir;
      repeat (20) @(posedge mclk);
   endtask
   // Whole periods at even duty; odd offset keeps edges off mclk
   task automatic burst(input int n);
      #7;
      for (int i = 0; i < n; i++) begin
         #HALF_NS step_clock = 1'b1;
         #HALF_NS step_clock = 1'b0;
      end
      repeat (20) @(posedge mclk);
   endtask
   // Reset and enable levels
   task automatic set_pin(input logic rst_n, input logic en);
      @(posedge mclk);
      sequencer_reset_n <= rst_n;
      enable <= en;
      repeat (12) @(posedge mclk);
   endtask
endmodule

//--- sps_stepper_phase_sequencer_bench.sv
`timescale 1ns/1ps
`include "sps_map.svh"
// Self-checking bench: registers, coil sequence, enable and fault paths
module sps_stepper_phase_sequencer_bench;
   // Clock, reset, pins
   logic mclk, resetn, chop_on, over_current, over_heat;
   logic step_clock, step_edge_select, excitation_select, rotation_direction;
   logic sequencer_reset_n, enable, fault_n_in, fault_n_out, fault_n_oe;
   logic first_coil_fwd_drive, first_coil_rev_drive;
   logic second_coil_fwd_drive, second_coil_rev_drive;
   // APB
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   // Expectations and bookkeeping
   logic [3:0]  drv_q [$];
   logic [33:0] apb_q [$];
   logic [33:0] note;
   logic [3:0]  drv_last = 4'h0;
   logic [3:0]  pat [8] = '{`SPS_PAT_0, `SPS_PAT_1, `SPS_PAT_2, `SPS_PAT_3,
                            `SPS_PAT_4, `SPS_PAT_5, `SPS_PAT_6, `SPS_PAT_7};
   logic [7:0]  blank;
   logic        exc, edg, dir;
   sps_pkg::sps_pos_t pos;
   int fails = 0, total_checks = 0, cycles = 0, n;
   wire logic [3:0] drv = {first_coil_fwd_drive, first_coil_rev_drive,
                           second_coil_fwd_drive, second_coil_rev_drive};
   // Fault line has a pull-up
   assign fault_n_in = fault_n_oe ? fault_n_out : 1'b1;

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   sps_stepper_phase_sequencer dut (
      .mclk, .resetn, .step_clock, .step_edge_select, .excitation_select,
      .rotation_direction, .sequencer_reset_n, .enable, .chop_on, .over_current,
      .over_heat, .first_coil_fwd_drive, .first_coil_rev_drive, .second_coil_fwd_drive,
      .second_coil_rev_drive, .fault_n_in, .fault_n_out, .fault_n_oe, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   sps_motion_ctrl ctl (.mclk, .step_clock, .step_edge_select, .excitation_select,
      .rotation_direction, .sequencer_reset_n, .enable);

   // Compare and count
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Counts, then verdict
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One APB transfer; reads note expected data, all note expected error
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
      apb_q.push_back({!wr, err, d});
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Next position for one accepted step edge
   function automatic sps_pkg::sps_pos_t next_pos(sps_pkg::sps_pos_t p);
      sps_pkg::sps_pos_t d;
      d = (exc || p[0]) ? 3'h1 : 3'h2;
      return dir ? p - d : p + d;
   endfunction

   // Retires the oldest note whenever an APB answer or a drive change shows
   always @(posedge mclk) begin
      if (resetn && psel && penable && pready) begin
         note = apb_q.size() ? apb_q.pop_front() : 'x;
         check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
         if (note[33]) check("prdata", note[31:0], prdata);
      end
      if (resetn && drv !== drv_last) begin
         check("drives", {28'h0, drv_q.size() ? drv_q.pop_front() : 4'hx}, {28'h0, drv});
      end
      drv_last <= drv;
   end
   // Hang limit, far above the expected run
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      resetn = 1'b0;
      {chop_on, over_current, over_heat, psel, penable, pwrite} = 6'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(86));
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      // Register default, write-back, read-only and unmapped places
      apb(1'b0, `SPS_OFS_BLANK, 32'(`SPS_BLANK_CYC), 1'b0);
      blank = 8'(16 + $urandom % 16);
      apb(1'b1, `SPS_OFS_BLANK, {24'h0, blank}, 1'b0);
      apb(1'b0, `SPS_OFS_BLANK, {24'h0, blank}, 1'b0);
      apb(1'b1, `SPS_OFS_STATUS, 32'h0, 1'b1);
      apb(1'b0, 8'h0c, 32'h0, 1'b1);
      // Sequencer reset release
      pos = `SPS_POS_INIT;
      drv_q.push_back(pat[pos]);
      ctl.set_pin(1'b1, 1'b1);
      // Every mode and direction, switching pattern with the phase kept
      for (int m = 0; m < 8; m++) begin
         {dir, edg, exc} = 3'(m);
         ctl.set_mode(exc, edg, dir);
         n = 1 + $urandom % 3;
         for (int i = 0; i < n; i++) begin
            pos = next_pos(pos);
            drv_q.push_back(pat[pos]);
            if (!edg) begin
               pos = next_pos(pos);
               drv_q.push_back(pat[pos]);
            end
         end
         ctl.burst(n);
      end
      apb(1'b0, `SPS_OFS_STATUS, {18'h0, 1'b0, pat[pos], 3'b001, dir, edg, exc, pos}, 1'b0);
      // Enable low: drives off, edges ignored, then resume in place
      drv_q.push_back(4'h0);
      ctl.set_pin(1'b1, 1'b0);
      ctl.burst(2);
      drv_q.push_back(pat[pos]);
      ctl.set_pin(1'b1, 1'b1);
      // Overheat, then overcurrent inside and after blanking
      for (int c = 0; c < 2; c++) begin
         if (c == 1) begin
            @(posedge mclk);
            chop_on <= 1'b1;
            over_current <= 1'b1;
            repeat (8) @(posedge mclk);
            over_current <= 1'b0;
            repeat (blank + 8) @(posedge mclk);
            @(negedge mclk);
            check("fault_n_oe", 32'h0, {31'h0, fault_n_oe});
         end
         drv_q.push_back(4'h0);
         @(posedge mclk);
         over_heat <= (c == 0);
         over_current <= (c == 1);
         repeat (10) @(posedge mclk);
         over_heat <= 1'b0;
         over_current <= 1'b0;
         chop_on <= 1'b0;
         ctl.burst(2);
         @(negedge mclk);
         check("fault_n_in", 32'h0, {31'h0, fault_n_in});
         pos = `SPS_POS_INIT;
         drv_q.push_back(pat[pos]);
         ctl.set_pin(1'b0, 1'b1);
         ctl.set_pin(1'b1, 1'b1);
      end
      repeat (40) @(posedge mclk);
      check("pending", 32'h0, 32'(drv_q.size() + apb_q.size()));
      print_verdict();
   end
endmodule
